/* File: avec_map.svh */
// register offsets, field positions, reset values and vector constants of the autovector unit
`ifndef AVEC_MAP_SVH
`define AVEC_MAP_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_SETUP 8'h00
`define OFS_USB_EN 8'h04
`define OFS_USB_PEND 8'h08
`define OFS_FIFO_EN 8'h0c
`define OFS_FIFO_PEND 8'h10
`define OFS_VECTOR 8'h14

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SETUP_USB_AV_BIT 0
`define SETUP_FIFO_AV_BIT 1
`define SETUP_RST 2'h0
`define USB_EN_RST 32'h00000000
`define FIFO_EN_RST 14'h0000
`define VEC_FIFO_LSB 8
`define VEC_USB_LINE_BIT 16
`define VEC_FIFO_LINE_BIT 17

// ----------------------------------------------------------------
// source slots and vector codes
// ----------------------------------------------------------------
`define USB_SLOTS 32
`define FIFO_SLOTS 14
`define USB_SLOT_VALID 32'hf3fdff5f
`define USB_VEC_BASE 8'h00
`define FIFO_VEC_BASE 8'h80

// ----------------------------------------------------------------
// fixed code addresses of the two shared lines
// ----------------------------------------------------------------
`define USB_ISR_ADDR 16'h0043
`define USB_PAGE_ADDR 16'h0044
`define USB_OPND_ADDR 16'h0045
`define FIFO_ISR_ADDR 16'h0053
`define FIFO_PAGE_ADDR 16'h0054
`define FIFO_OPND_ADDR 16'h0055

`endif

/* File: avec_pkg.sv */
// types shared by the autovector unit
package avec_pkg;
  typedef logic [7:0] vec_byte_t;
  typedef logic [15:0] code_addr_t;
  typedef logic [31:0] bus_word_t;
endpackage

/* File: sticky_bank.sv */
// bank of sticky pending bits, set wins over clear
`timescale 1ns/1ps
module sticky_bank #(
  parameter int W = 8
) (
  // clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // set and clear strobes
  input wire logic [W-1:0] set,
  input wire logic [W-1:0] clr,
  // pending state
  output logic [W-1:0] pend
);
  genvar k;
  generate
    for (k = 0; k < W; k++) begin : g_bit
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          pend[k] <= 1'b0;
        end else if (ce) begin
          if (set[k]) begin
            pend[k] <= 1'b1;
          end else if (clr[k]) begin
            pend[k] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule

/* File: prio_pick.sv */
// picks the lowest-numbered active request
`timescale 1ns/1ps
module prio_pick #(
  parameter int W = 8,
  parameter int IW = 3
) (
  // requests
  input wire logic [W-1:0] req,
  // winner
  output logic any,
  output logic [IW-1:0] idx
);
  always_comb begin
    any = |req;
    idx = '0;
    for (int i = W - 1; i >= 0; i--) begin
      if (req[i]) begin
        idx = IW'(i);
      end
    end
  end
endmodule

/* File: avec_unit.sv */
// second-level vectoring of the usb and fifo shared interrupt lines
`timescale 1ns/1ps
`include "avec_map.svh"
module avec_unit
  import avec_pkg::*;
(
  // clock, reset, enable
  input wire logic CORE_CLK,
  input wire logic RST_N,
  input wire logic CE,
  // ahb-lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic HREADY,
  input wire logic [31:0] HWDATA,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  // interrupt source events
  input wire logic [31:0] USB_EVENT,
  input wire logic [13:0] FIFO_EVENT,
  // processor core interrupt side
  output logic USB_INT,
  output logic FIFO_INT,
  input wire logic INT_TAKEN_USB,
  input wire logic INT_TAKEN_FIFO,
  input wire logic [15:0] CPU_PC,
  output logic STACK_PUSH,
  output logic [15:0] STACK_DATA,
  output logic JUMP_LOAD,
  output logic [15:0] JUMP_ADDR,
  // processor core fetch side
  input wire logic [15:0] FETCH_ADDR,
  input wire logic [7:0] MEM_BYTE,
  output logic [7:0] FETCH_BYTE
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [1:0] setup_reg;
  logic [31:0] usb_en_reg;
  logic [13:0] fifo_en_reg;
  logic [31:0] usb_pend;
  logic [13:0] fifo_pend;
  logic [31:0] usb_set;
  logic [31:0] usb_clr;
  logic [13:0] fifo_clr;
  logic [31:0] usb_act;
  logic [13:0] fifo_act;
  logic usb_any;
  logic fifo_any;
  logic [4:0] usb_idx;
  logic [3:0] fifo_idx;
  vec_byte_t usb_vec_reg;
  vec_byte_t fifo_vec_reg;
  vec_byte_t usb_vec_next;
  vec_byte_t fifo_vec_next;
  logic usb_int_reg;
  logic fifo_int_reg;
  logic push_reg;
  code_addr_t stack_reg;
  logic jump_reg;
  code_addr_t jump_addr_reg;
  vec_byte_t fetch_reg;
  vec_byte_t fetch_next;
  logic addr_ok;
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  bus_word_t rdata_reg;
  bus_word_t rdata_next;
  logic usb_av;
  logic fifo_av;

  assign usb_av = setup_reg[`SETUP_USB_AV_BIT];
  assign fifo_av = setup_reg[`SETUP_FIFO_AV_BIT];

  // ----------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------
  assign addr_ok = HSEL && HREADY && HTRANS[1];
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign HRDATA = rdata_reg;

  always_comb begin
    rdata_next = '0;
    unique case (HADDR[7:0])
      `OFS_SETUP: rdata_next = {30'h00000000, setup_reg};
      `OFS_USB_EN: rdata_next = usb_en_reg;
      `OFS_USB_PEND: rdata_next = usb_pend;
      `OFS_FIFO_EN: rdata_next = {18'h00000, fifo_en_reg};
      `OFS_FIFO_PEND: rdata_next = {18'h00000, fifo_pend};
      `OFS_VECTOR: rdata_next = {14'h0000, fifo_int_reg, usb_int_reg, fifo_vec_reg, usb_vec_reg};
      default: rdata_next = '0;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= 32'h00000000;
    end else if (CE) begin
      wr_pend_reg <= addr_ok && HWRITE;
      if (addr_ok) begin
        wr_addr_reg <= HADDR[7:0];
      end
      if (addr_ok && !HWRITE) begin
        rdata_reg <= rdata_next;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      setup_reg <= `SETUP_RST;
      usb_en_reg <= `USB_EN_RST;
      fifo_en_reg <= `FIFO_EN_RST;
    end else if (CE && wr_pend_reg) begin
      if (wr_addr_reg == `OFS_SETUP) begin
        setup_reg <= HWDATA[1:0];
      end
      if (wr_addr_reg == `OFS_USB_EN) begin
        usb_en_reg <= HWDATA & `USB_SLOT_VALID;
      end
      if (wr_addr_reg == `OFS_FIFO_EN) begin
        fifo_en_reg <= HWDATA[13:0];
      end
    end
  end

  // write-one-to-clear on the pending registers
  assign usb_clr = (wr_pend_reg && wr_addr_reg == `OFS_USB_PEND) ? HWDATA : 32'h00000000;
  assign fifo_clr = (wr_pend_reg && wr_addr_reg == `OFS_FIFO_PEND) ? HWDATA[13:0] : 14'h0000;

  // ----------------------------------------------------------------
  // pending sources
  // ----------------------------------------------------------------
  // two banks
  assign usb_set = USB_EVENT & `USB_SLOT_VALID;

  sticky_bank #(.W(`USB_SLOTS)) u_usb_bank (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .set(usb_set),
    .clr(usb_clr),
    .pend(usb_pend)
  );

  sticky_bank #(.W(`FIFO_SLOTS)) u_fifo_bank (
    .clk(CORE_CLK),
    .rst_n(RST_N),
    .ce(CE),
    .set(FIFO_EVENT),
    .clr(fifo_clr),
    .pend(fifo_pend)
  );

  assign usb_act = usb_pend & usb_en_reg;
  assign fifo_act = fifo_pend & fifo_en_reg;

  // ----------------------------------------------------------------
  // priority and vector bytes
  // ----------------------------------------------------------------
  prio_pick #(.W(`USB_SLOTS), .IW(5)) u_usb_pick (
    .req(usb_act),
    .any(usb_any),
    .idx(usb_idx)
  );

  prio_pick #(.W(`FIFO_SLOTS), .IW(4)) u_fifo_pick (
    .req(fifo_act),
    .any(fifo_any),
    .idx(fifo_idx)
  );

  assign usb_vec_next = `USB_VEC_BASE | {1'b0, usb_idx, 2'b00};
  assign fifo_vec_next = `FIFO_VEC_BASE | {2'b00, fifo_idx, 2'b00};

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      usb_vec_reg <= `USB_VEC_BASE;
      fifo_vec_reg <= `FIFO_VEC_BASE;
    end else if (CE) begin
      usb_vec_reg <= usb_vec_next;
      fifo_vec_reg <= fifo_vec_next;
    end
  end

  // ----------------------------------------------------------------
  // shared lines
  // ----------------------------------------------------------------
  // level while an enabled source is pending
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      usb_int_reg <= 1'b0;
      fifo_int_reg <= 1'b0;
    end else if (CE) begin
      usb_int_reg <= usb_any;
      fifo_int_reg <= fifo_any;
    end
  end

  assign USB_INT = usb_int_reg;
  assign FIFO_INT = fifo_int_reg;

  // ----------------------------------------------------------------
  // interrupt entry: push pc and load fixed address
  // ----------------------------------------------------------------
  // fixed entry
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      push_reg <= 1'b0;
      jump_reg <= 1'b0;
      stack_reg <= 16'h0000;
      jump_addr_reg <= 16'h0000;
    end else if (CE) begin
      push_reg <= INT_TAKEN_USB || INT_TAKEN_FIFO;
      jump_reg <= INT_TAKEN_USB || INT_TAKEN_FIFO;
      if (INT_TAKEN_USB || INT_TAKEN_FIFO) begin
        stack_reg <= CPU_PC;
        jump_addr_reg <= INT_TAKEN_USB ? `USB_ISR_ADDR : `FIFO_ISR_ADDR;
      end
    end
  end

  assign STACK_PUSH = push_reg;
  assign STACK_DATA = stack_reg;
  assign JUMP_LOAD = jump_reg;
  assign JUMP_ADDR = jump_addr_reg;

  // ----------------------------------------------------------------
  // operand substitution on fetch
  // ----------------------------------------------------------------
  always_comb begin
    fetch_next = MEM_BYTE;
    if (usb_av && FETCH_ADDR == `USB_OPND_ADDR) begin
      fetch_next = usb_vec_reg;
    end else if (fifo_av && FETCH_ADDR == `FIFO_OPND_ADDR) begin
      fetch_next = fifo_vec_reg;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      fetch_reg <= 8'h00;
    end else if (CE) begin
      fetch_reg <= fetch_next;
    end
  end

  assign FETCH_BYTE = fetch_reg;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  property p_usb_line;
    @(posedge CORE_CLK) disable iff (!RST_N)
    CE |=> (USB_INT == $past(|(usb_pend & usb_en_reg)));
  endproperty
  a_usb_line: assert property (p_usb_line) else $error("usb line not following pending");

  property p_fifo_line;
    @(posedge CORE_CLK) disable iff (!RST_N)
    CE |=> (FIFO_INT == $past(|(fifo_pend & fifo_en_reg)));
  endproperty
  a_fifo_line: assert property (p_fifo_line) else $error("fifo line not following pending");

  property p_usb_entry;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && INT_TAKEN_USB) |=> (STACK_PUSH && JUMP_LOAD && JUMP_ADDR == 16'h0043 && STACK_DATA == $past(CPU_PC));
  endproperty
  a_usb_entry: assert property (p_usb_entry) else $error("usb entry wrong");

  property p_fifo_entry;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && INT_TAKEN_FIFO && !INT_TAKEN_USB) |=> (STACK_PUSH && JUMP_ADDR == 16'h0053);
  endproperty
  a_fifo_entry: assert property (p_fifo_entry) else $error("fifo entry wrong");

  property p_usb_subst;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && usb_av && FETCH_ADDR == 16'h0045) |=> (FETCH_BYTE == $past(usb_vec_reg));
  endproperty
  a_usb_subst: assert property (p_usb_subst) else $error("usb operand not replaced");

  property p_fifo_subst;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && fifo_av && FETCH_ADDR == 16'h0055) |=> (FETCH_BYTE == $past(fifo_vec_reg));
  endproperty
  a_fifo_subst: assert property (p_fifo_subst) else $error("fifo operand not replaced");

  property p_pass;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && !(usb_av && FETCH_ADDR == 16'h0045) && !(fifo_av && FETCH_ADDR == 16'h0055))
      |=> (FETCH_BYTE == $past(MEM_BYTE));
  endproperty
  a_pass: assert property (p_pass) else $error("memory byte altered");

  property p_usb_top;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && usb_act[0]) |=> (usb_vec_reg == 8'h00);
  endproperty
  a_usb_top: assert property (p_usb_top) else $error("setup data vector wrong");

  property p_ack_vec;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && usb_act[6] && usb_act[5:0] == 6'h00) |=> (usb_vec_reg == 8'h18);
  endproperty
  a_ack_vec: assert property (p_ack_vec) else $error("handshake vector wrong");

  property p_fifo_top;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && fifo_act[0]) |=> (fifo_vec_reg == 8'h80);
  endproperty
  a_fifo_top: assert property (p_fifo_top) else $error("fifo best rank lost");

  property p_wave_req;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && fifo_act == 14'h2000) |=> (fifo_vec_reg == 8'hb4);
  endproperty
  a_wave_req: assert property (p_wave_req) else $error("waveform request vector wrong");

  property p_set_wins;
    @(posedge CORE_CLK) disable iff (!RST_N)
    (CE && USB_EVENT[0]) |=> usb_pend[0];
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("usb event lost");

endmodule

/* File: avec_core_model.sv */
// processor core model driving interrupt takes and code fetches
`timescale 1ns/1ps
module avec_core_model (
  // clock
  input wire logic clk,
  // interrupt entry
  output logic taken_usb,
  output logic taken_fifo,
  output logic [15:0] cpu_pc,
  // code fetch
  output logic [15:0] fetch_addr,
  output logic [7:0] mem_byte
);
  // ----------------------------------------
  // code memory: fixed pattern per address
  // ----------------------------------------
  assign mem_byte = fetch_addr[7:0] ^ 8'ha5;
  initial begin
    taken_usb = 1'b0;
    taken_fifo = 1'b0;
    cpu_pc = 16'h0000;
    fetch_addr = 16'h0000;
  end
  // ----------------------------------------
  // requests, changed just after a rising edge
  // ----------------------------------------
  task automatic take(input logic fifo, input logic [15:0] pc);
    @(posedge clk);
    taken_usb <= ~fifo;
    taken_fifo <= fifo;
    cpu_pc <= pc;
  endtask
  task automatic idle();
    @(posedge clk);
    taken_usb <= 1'b0;
    taken_fifo <= 1'b0;
  endtask
  task automatic fetch(input logic [15:0] a);
    @(posedge clk);
    fetch_addr <= a;
  endtask
endmodule

/* File: tb_interrupt_autovector_unit.sv */
// self-checking bench of the autovector unit
`timescale 1ns/1ps
`include "avec_map.svh"
module tb_interrupt_autovector_unit;
  logic clk, rst_n, ce, hsel, hwrite;
  logic [31:0] haddr, hwdata, usb_ev;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [13:0] fifo_ev;
  wire logic [31:0] hrdata;
  wire logic hreadyout, hresp, usb_int, fifo_int, stack_push, jump_load, taken_usb, taken_fifo;
  wire logic [15:0] stack_data, jump_addr, cpu_pc, fetch_addr;
  wire logic [7:0] mem_byte, fetch_byte;
  int err_count = 0;
  int num_checks = 0;

  avec_unit dut (.CORE_CLK(clk), .RST_N(rst_n), .CE(ce), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HREADY(hreadyout), .HWDATA(hwdata), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .USB_EVENT(usb_ev), .FIFO_EVENT(fifo_ev), .USB_INT(usb_int),
    .FIFO_INT(fifo_int), .INT_TAKEN_USB(taken_usb), .INT_TAKEN_FIFO(taken_fifo), .CPU_PC(cpu_pc),
    .STACK_PUSH(stack_push), .STACK_DATA(stack_data), .JUMP_LOAD(jump_load), .JUMP_ADDR(jump_addr),
    .FETCH_ADDR(fetch_addr), .MEM_BYTE(mem_byte), .FETCH_BYTE(fetch_byte));
  avec_core_model u_core (.clk(clk), .taken_usb(taken_usb), .taken_fifo(taken_fifo), .cpu_pc(cpu_pc),
    .fetch_addr(fetch_addr), .mem_byte(mem_byte));

  always #25 clk = ~clk;

  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      err_count++;
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------
  // ahb-lite master
  // ----------------------------------------
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 16);
    if (hreadyout !== 1'b1) begin
      chk("hready", 1, hreadyout);
      give_verdict();
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h000000, a};
    hwrite <= w;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    r = hrdata;
    chk("response", 0, hresp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h00000000, r);
    chk(what, exp, r);
  endtask
  task automatic pulse(input logic [31:0] u, input logic [13:0] f);
    @(posedge clk);
    usb_ev <= u;
    fifo_ev <= f;
    @(posedge clk);
    usb_ev <= 32'h00000000;
    fifo_ev <= 14'h0000;
    @(posedge clk);
    #1;
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic src(input logic fifo, input int k);
    logic [31:0] v;
    if (fifo) pulse(32'h0, 14'(1 << k)); else pulse(32'h1 << k, 14'h0);
    chk("line raised", 1, fifo ? fifo_int : usb_int);
    bus(1'b0, `OFS_VECTOR, 32'h0, v);
    chk("vector byte", 32'(fifo ? 8'h80 + 8'(4 * k) : 8'(4 * k)), fifo ? v[15:8] : v[7:0]);
    chk("line bit", 1, fifo ? v[`VEC_FIFO_LINE_BIT] : v[`VEC_USB_LINE_BIT]);
    wr(fifo ? `OFS_FIFO_PEND : `OFS_USB_PEND, 32'h1 << k);
    @(posedge clk);
    #1;
    chk("line cleared", 0, fifo ? fifo_int : usb_int);
  endtask
  task automatic t_walk();
    wr(`OFS_USB_EN, 32'hffffffff);
    rd_chk("usb enable", `OFS_USB_EN, `USB_SLOT_VALID);
    wr(`OFS_FIFO_EN, 32'h00003fff);
    for (int k = 0; k < 32; k++) begin
      if (`USB_SLOT_VALID & (32'h1 << k)) src(1'b0, k);
    end
    for (int k = 0; k < 14; k++) begin
      src(1'b1, k);
    end
  endtask
  task automatic t_prio();
    pulse(32'h80001000, 14'h2020);
    rd_chk("both winners", `OFS_VECTOR, 32'h00039430);
    wr(`OFS_USB_PEND, 32'h00001000);
    wr(`OFS_FIFO_PEND, 32'h00000020);
    rd_chk("next winners", `OFS_VECTOR, 32'h0003b47c);
    wr(`OFS_USB_PEND, 32'h80000000);
    wr(`OFS_FIFO_PEND, 32'h00002000);
  endtask
  task automatic t_mask();
    wr(`OFS_USB_EN, 32'h00000000);
    pulse(32'h00000001, 14'h0);
    chk("disabled line", 0, usb_int);
    rd_chk("disabled pend", `OFS_USB_PEND, 32'h00000001);
    wr(`OFS_USB_PEND, 32'h00000001);
    wr(`OFS_USB_EN, 32'hffffffff);
    pulse(32'h00000020, 14'h0);
    chk("reserved line", 0, usb_int);
    rd_chk("reserved pend", `OFS_USB_PEND, 32'h00000000);
  endtask
  task automatic t_freeze();
    @(posedge clk);
    ce <= 1'b0;
    pulse(32'h00000001, 14'h0001);
    chk("frozen line", 0, {usb_int, fifo_int});
    @(posedge clk);
    ce <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    #1;
    chk("event while frozen", 0, {usb_int, fifo_int});
    rd_chk("frozen pend", `OFS_USB_PEND, 32'h00000000);
  endtask
  task automatic t_entry();
    u_core.take(1'b0, 16'h1234);
    u_core.take(1'b1, 16'hbeef);
    #1;
    chk("usb entry", {16'h1234, `USB_ISR_ADDR}, {stack_data, jump_addr});
    chk("usb entry pulses", 32'h00000003, {stack_push, jump_load});
    u_core.idle();
    #1;
    chk("fifo entry", {16'hbeef, `FIFO_ISR_ADDR}, {stack_data, jump_addr});
    chk("fifo entry pulses", 32'h00000003, {stack_push, jump_load});
    @(posedge clk);
    #1;
    chk("pulse end", 0, {stack_push, jump_load});
  endtask
  task automatic t_fetch();
    logic [1:0] cfg [9] = '{2'd0, 2'd0, 2'd1, 2'd1, 2'd2, 2'd2, 2'd3, 2'd3, 2'd3};
    logic [15:0] adr [9] = '{`USB_OPND_ADDR, `FIFO_OPND_ADDR, `USB_OPND_ADDR, `FIFO_OPND_ADDR,
      `USB_OPND_ADDR, `FIFO_OPND_ADDR, `USB_PAGE_ADDR, `FIFO_PAGE_ADDR, `USB_ISR_ADDR};
    logic [7:0] exp;
    pulse(32'h00000200, 14'h0100);
    for (int i = 0; i < 9; i++) begin
      exp = adr[i][7:0] ^ 8'ha5;
      if (adr[i] == `USB_OPND_ADDR && cfg[i][0]) exp = 8'h24;
      if (adr[i] == `FIFO_OPND_ADDR && cfg[i][1]) exp = 8'ha0;
      wr(`OFS_SETUP, {30'h0, cfg[i]});
      u_core.fetch(adr[i]);
      @(posedge clk);
      #1;
      chk("fetch byte", {24'h0, exp}, {24'h0, fetch_byte});
    end
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h00000000;
    hwdata = 32'h00000000;
    htrans = 2'b00;
    hsize = 3'h2;
    usb_ev = 32'h00000000;
    fifo_ev = 14'h0000;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk("setup reset", `OFS_SETUP, 32'h00000000);
    rd_chk("vector reset", `OFS_VECTOR, 32'h00008000);
    rd_chk("unmapped", 8'h1c, 32'h00000000);
    chk("lines reset", 0, {usb_int, fifo_int});
    t_walk();
    t_prio();
    t_mask();
    t_freeze();
    t_entry();
    t_fetch();
    give_verdict();
  end
endmodule
